/* verilog/hsr_regs.vh */
// register offsets, field positions, reset values and timing counts
// assumes: included by the register bank and its helper modules
`ifndef HSR_REGS_VH
`define HSR_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define HSR_OFS_HUB_FORCE      12'h014
`define HSR_OFS_LIST_FILLED    12'h334
`define HSR_OFS_DONE_TIMEOUT   12'h338
`define HSR_OFS_READ_POINTER   12'h33c
`define HSR_OFS_ACT_STATUS     12'h340

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define HSR_BIT_ASYNC_FILL     0
`define HSR_BIT_INTR_FILL      1
`define HSR_BIT_ISO_FILL       2
`define HSR_BIT_FORCE_HUB_CONFIGURED     0
`define HSR_PTR_ADDR_MSB       15
`define HSR_PTR_BANK_LSB       16
`define HSR_PTR_BANK_MSB       17

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define HSR_RST_FILLED         3'h0
`define HSR_RST_TIMEOUT        32'h0000_0000
`define HSR_RST_POINTER        16'h0000
`define HSR_RST_BANK           2'h0

// ---------------------------------------------------------------
// timing: one millisecond at 40 mhz
// ---------------------------------------------------------------
`define HSR_CLK_KHZ            40000
`define HSR_MS_CYCLES          (`HSR_CLK_KHZ * 1)

`endif

/* verilog/hsr_read_ptr.v */
// four bank read pointers with load and auto-increment
// assumes: load and advance are single-cycle pulses from the register bank
`timescale 1ns/1ps

module hsr_read_ptr
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_load,
  input  wire [1:0]  i_load_bank,
  input  wire [15:0] i_load_addr,
  input  wire        i_adv,
  input  wire [1:0]  i_adv_bank,
  output wire [63:0] o_ptr_flat
);
`include "hsr_regs.vh"

  // ---------------------------------------------------------------
  // per bank pointer
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_bank
      reg [15:0] ptr_q;
      // a new start address wins over an advance in the same cycle
      always @(posedge i_ref_clk)
      begin
        if (i_rst)
          ptr_q <= `HSR_RST_POINTER;
        else if (i_load && (i_load_bank == g))
          ptr_q <= i_load_addr;
        else if (i_adv && (i_adv_bank == g))
          ptr_q <= ptr_q + 16'h0001; // wraps in the 16-bit space
      end
      assign o_ptr_flat[16*g+15:16*g] = ptr_q;
    end
  endgenerate

endmodule // hsr_read_ptr

/* verilog/hsr_done_timer.v */
// millisecond done time-out for completed async descriptors
// assumes: i_done is a one-cycle pulse per completed async descriptor
`timescale 1ns/1ps

module hsr_done_timer
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [31:0] i_timeout_ms,
  input  wire        i_done,
  input  wire        i_ack,
  output reg         o_expired
);
`include "hsr_regs.vh"

  // one millisecond fits in 16 bits at this clock, so keep the low half on purpose
  localparam [31:0] MS_CYC_W = `HSR_MS_CYCLES;
  localparam [15:0] MS_CYC   = MS_CYC_W[15:0];

  reg [15:0] tick_q;
  reg [31:0] ms_q;
  reg        run_q;

  // ---------------------------------------------------------------
  // count whole milliseconds since the first pending completion
  // ---------------------------------------------------------------
  // a zero time-out never arms, so a cleared register keeps it quiet
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      tick_q    <= 16'h0000;
      ms_q      <= 32'h0000_0000;
      run_q     <= 1'b0;
      o_expired <= 1'b0;
    end
    else
    begin
      if (i_done && !run_q && (i_timeout_ms != 32'h0000_0000))
      begin
        run_q  <= 1'b1;
        tick_q <= 16'h0000;
        ms_q   <= 32'h0000_0000;
      end
      else if (run_q)
      begin
        if (tick_q == MS_CYC - 16'h0001)
        begin
          tick_q <= 16'h0000;
          if (ms_q + 32'h0000_0001 >= i_timeout_ms)
          begin
            run_q <= 1'b0;
            ms_q  <= 32'h0000_0000;
          end
          else
            ms_q <= ms_q + 32'h0000_0001;
        end
        else
          tick_q <= tick_q + 16'h0001;
      end
      // expiry wins over a same-cycle acknowledge
      if (run_q && (tick_q == MS_CYC - 16'h0001)
          && (ms_q + 32'h0000_0001 >= i_timeout_ms))
        o_expired <= 1'b1;
      else if (i_ack)
        o_expired <= 1'b0;
    end
  end

endmodule // hsr_done_timer

/* verilog/hsr_sched_regs.v */
// scheduler, memory read pointer and hub force control registers
// assumes: axi4-lite master on i_ref_clk, scheduler and memory logic alongside
//
// How it works
// - a set async fill flag lets the scheduler walk the async descriptor area.
// - a clear async fill flag makes the scheduler skip that area entirely.
// - the done time-out register (reset zero) counts milliseconds and then raises the interrupt if enabled.
// - only async descriptor completions start the done time-out.
// - writing a read start address loads that bank, and each bank read advances it.
// - bits 17 to 16 select one of four banks for pio accesses only.
// - bits 15 to 0 hold the start address for pio reads only.
// - writing 1 to the force bit puts the hub into configured state at once.
// - writing 0 leaves the hub state alone and upper bits are read-only.
// - the force bit always reads back as 0.
// - the interrupt and iso fill flags gate their areas the same way.
// - a set flag makes the scheduler walk only valid, non-skipped headers.
`timescale 1ns/1ps

module hsr_sched_regs
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // axi4-lite slave
  input  wire [11:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [11:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // scheduler side
  input  wire        i_hdr_valid,
  input  wire        i_hdr_skip,
  input  wire        i_async_done,
  input  wire        i_periodic_done,
  input  wire        i_done_int_en,
  input  wire        i_done_int_ack,
  output reg  [2:0]  o_walk_area,
  output reg         o_done_int,
  // pio memory side
  input  wire        i_pio_read,
  input  wire        i_pio_write,
  output reg  [1:0]  o_pio_bank,
  output reg  [15:0] o_pio_addr,
  output reg         o_pio_is_read,
  // internal hub
  output reg         o_hub_force_cfg
);
`include "hsr_regs.vh"

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg  [2:0]  fill_q;
  reg  [31:0] timeout_q;
  reg  [1:0]  bank_q;
  reg  [11:0] aw_q;
  reg  [31:0] w_q;
  reg  [3:0]  ws_q;
  reg         aw_have_q;
  reg         w_have_q;
  wire [63:0] ptr_flat;
  wire        expired;
  wire        wr_go;
  wire        rd_go;
  wire        hit_wr;
  wire [31:0] wmask;
  reg  [31:0] rd_d;
  reg         rd_ok_d;
  reg         wr_ok;

  // ---------------------------------------------------------------
  // write channel capture, address and data in either order
  // ---------------------------------------------------------------
  assign o_awready = !aw_have_q && !o_bvalid;
  assign o_wready  = !w_have_q && !o_bvalid;
  assign wr_go     = aw_have_q && w_have_q && !o_bvalid;
  assign wmask     = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= 12'h000;
      w_q       <= 32'h0000_0000;
      ws_q      <= 4'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_q      <= i_awaddr;
        aw_have_q <= 1'b1;
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (i_wvalid && o_wready)
      begin
        w_q      <= i_wdata;
        ws_q     <= i_wstrb;
        w_have_q <= 1'b1;
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  // address decode for writes; unmapped returns slverr
  always @*
  begin
    case ({aw_q[11:2], 2'b00})
      `HSR_OFS_HUB_FORCE,
      `HSR_OFS_LIST_FILLED,
      `HSR_OFS_DONE_TIMEOUT,
      `HSR_OFS_READ_POINTER,
      `HSR_OFS_ACT_STATUS:   wr_ok = 1'b1;
      default:               wr_ok = 1'b0;
    endcase
  end

  assign hit_wr = wr_go && ({aw_q[11:2], 2'b00} == `HSR_OFS_READ_POINTER)
                  && ws_q[0] && ws_q[1] && ws_q[2];

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      fill_q          <= `HSR_RST_FILLED;
      timeout_q       <= `HSR_RST_TIMEOUT;
      bank_q          <= `HSR_RST_BANK;
      o_hub_force_cfg <= 1'b0;
    end
    else
    begin
      if (wr_go && ({aw_q[11:2], 2'b00} == `HSR_OFS_LIST_FILLED) && ws_q[0])
        fill_q <= w_q[2:0];
      if (wr_go && ({aw_q[11:2], 2'b00} == `HSR_OFS_DONE_TIMEOUT))
        timeout_q <= (timeout_q & ~wmask) | (w_q & wmask);
      if (hit_wr)
        bank_q <= w_q[`HSR_PTR_BANK_MSB:`HSR_PTR_BANK_LSB];
      if (wr_go && ({aw_q[11:2], 2'b00} == `HSR_OFS_HUB_FORCE) && ws_q[0]
          && w_q[`HSR_BIT_FORCE_HUB_CONFIGURED])
        o_hub_force_cfg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= 2'b00;
    end
    else if (wr_go)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? 2'b00 : 2'b10;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read channel; one cycle to rvalid, held until rready
  // ---------------------------------------------------------------
  assign o_arready = !o_rvalid;
  assign rd_go     = i_arvalid && o_arready;

  always @*
  begin
    rd_d    = 32'h0000_0000;
    rd_ok_d = 1'b1;
    case ({i_araddr[11:2], 2'b00})
      `HSR_OFS_HUB_FORCE:    rd_d = 32'h0000_0000;
      `HSR_OFS_LIST_FILLED:  rd_d = {29'h0, fill_q};
      `HSR_OFS_DONE_TIMEOUT: rd_d = timeout_q;
      `HSR_OFS_READ_POINTER: rd_d = {14'h0, bank_q,
                                     ptr_flat[16*bank_q +: 16]};
      `HSR_OFS_ACT_STATUS:   rd_d = {29'h0, o_hub_force_cfg, expired, o_done_int};
      default:               rd_ok_d = 1'b0;
    endcase
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= 2'b00;
    end
    else if (rd_go)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_d;
      o_rresp  <= rd_ok_d ? 2'b00 : 2'b10;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // per bank pointers
  // ---------------------------------------------------------------
  // load on write, step on read
  hsr_read_ptr u_ptr
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_load      (hit_wr),
    .i_load_bank (w_q[`HSR_PTR_BANK_MSB:`HSR_PTR_BANK_LSB]),
    .i_load_addr (w_q[`HSR_PTR_ADDR_MSB:0]),
    .i_adv       (i_pio_read),
    .i_adv_bank  (bank_q),
    .o_ptr_flat  (ptr_flat)
  );

  // pio address presented to memory; dma paths never look at these
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_pio_bank    <= `HSR_RST_BANK;
      o_pio_addr    <= `HSR_RST_POINTER;
      o_pio_is_read <= 1'b0;
    end
    else
    begin
      o_pio_bank    <= bank_q;
      o_pio_addr    <= ptr_flat[16*bank_q +: 16];
      o_pio_is_read <= i_pio_read && !i_pio_write;
    end
  end

  // ---------------------------------------------------------------
  // descriptor area gating
  // ---------------------------------------------------------------
  // header qualifiers come from the walker in the same cycle
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_walk_area <= 3'b000;
    else
    begin
      o_walk_area <= fill_q & {3{i_hdr_valid && !i_hdr_skip}};
    end
  end

  // ---------------------------------------------------------------
  // done time-out interrupt
  // ---------------------------------------------------------------
  // async completions only
  hsr_done_timer u_timer
  (
    .i_ref_clk    (i_ref_clk),
    .i_rst        (i_rst),
    .i_timeout_ms (timeout_q),
    .i_done       (i_async_done),
    .i_ack        (i_done_int_ack),
    .o_expired    (expired)
  );

  // periodic completions are deliberately not wired to the timer
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_done_int <= 1'b0;
    else
      o_done_int <= expired && i_done_int_en;
  end

  // i_periodic_done stays unconnected on purpose: a periodic or iso
  // completion must never start or feed the done time-out, so the
  // port only exists to keep the walker interface uniform

endmodule // hsr_sched_regs

/* verification/hsr_sched_regs_props.sv */
// concurrent checks on the register bank ports
// assumes: bound into hsr_sched_regs, single clock, sync reset
`timescale 1ns/1ps
module hsr_sched_regs_props
(
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire        o_rvalid,
  input wire [31:0] o_rdata,
  input wire        i_rready,
  input wire        o_bvalid,
  input wire [1:0]  o_bresp,
  input wire        i_bready,
  input wire        i_hdr_valid,
  input wire        i_hdr_skip,
  input wire [2:0]  o_walk_area,
  input wire        i_done_int_en,
  input wire        o_done_int,
  input wire        i_pio_read,
  input wire        i_pio_write,
  input wire        o_pio_is_read,
  input wire        o_hub_force_cfg
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_walk_gate; (i_hdr_skip || !i_hdr_valid) |=> o_walk_area == 3'h0; endproperty
  a_walk_gate: assert property (p_walk_gate)
    else $error("walk area set for skipped or invalid header");
  property p_hub_sticky; o_hub_force_cfg |=> o_hub_force_cfg; endproperty
  a_hub_sticky: assert property (p_hub_sticky)
    else $error("hub configured state dropped");
  property p_rd_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_rd_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data not held");
  property p_wr_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response not held");
  property p_int_off; !i_done_int_en |=> !o_done_int; endproperty
  a_int_off: assert property (p_int_off)
    else $error("interrupt while source disabled");
  property p_pio_rd; i_pio_read |=> o_pio_is_read; endproperty
  a_pio_rd: assert property (p_pio_rd)
    else $error("pio read not flagged");
  property p_pio_wr; i_pio_write && !i_pio_read |=> !o_pio_is_read; endproperty
  a_pio_wr: assert property (p_pio_wr)
    else $error("pio write flagged as read");
endmodule // hsr_sched_regs_props
bind hsr_sched_regs hsr_sched_regs_props u_props (.i_ref_clk, .i_rst, .i_arvalid, .o_arready,
  .o_rvalid, .o_rdata, .i_rready, .o_bvalid, .o_bresp, .i_bready, .i_hdr_valid, .i_hdr_skip,
  .o_walk_area, .i_done_int_en, .o_done_int, .i_pio_read, .i_pio_write, .o_pio_is_read,
  .o_hub_force_cfg);

/* verification/hsr_host_model.sv */
// host processor model: axi4-lite master with one write and one read task
// assumes: caller enters a task at any time; every change lands after an edge
`timescale 1ns/1ps
module hsr_host_model
(
  input  wire        i_ref_clk,
  output reg  [11:0] o_awaddr = 12'h0,
  output reg         o_awvalid = 1'b0,
  input  wire        i_awready,
  output reg  [31:0] o_wdata = 32'h0,
  output reg  [3:0]  o_wstrb = 4'hf,
  output reg         o_wvalid = 1'b0,
  input  wire        i_wready,
  input  wire [1:0]  i_bresp,
  input  wire        i_bvalid,
  output reg         o_bready = 1'b0,
  output reg  [11:0] o_araddr = 12'h0,
  output reg         o_arvalid = 1'b0,
  input  wire        i_arready,
  input  wire [31:0] i_rdata,
  input  wire [1:0]  i_rresp,
  input  wire        i_rvalid,
  output reg         o_rready = 1'b0
);
  // response ready rises with the request and drops once the answer is taken
  task wr(input [11:0] a, input [31:0] d, output [1:0] r);
    reg done;
    begin
      done = 1'b0;
      @(posedge i_ref_clk);
      o_awaddr <= a;
      o_wdata <= d;
      o_awvalid <= 1'b1;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      while (!done)
      begin
        @(posedge i_ref_clk);
        if (o_awvalid && i_awready) o_awvalid <= 1'b0;
        if (o_awvalid && i_awready) o_awaddr <= ~a;
        if (o_wvalid && i_wready) o_wvalid <= 1'b0;
        if (o_wvalid && i_wready) o_wdata <= ~d;
        if (i_bvalid && o_bready) r = i_bresp;
        if (i_bvalid && o_bready) done = 1'b1;
        if (i_bvalid && o_bready) o_bready <= 1'b0;
      end
    end
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    reg done;
    begin
      done = 1'b0;
      @(posedge i_ref_clk);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      while (!done)
      begin
        @(posedge i_ref_clk);
        if (o_arvalid && i_arready) o_arvalid <= 1'b0;
        if (o_arvalid && i_arready) o_araddr <= ~a;
        if (i_rvalid && o_rready) {r, d} = {i_rresp, i_rdata};
        if (i_rvalid && o_rready) done = 1'b1;
        if (i_rvalid && o_rready) o_rready <= 1'b0;
      end
    end
  endtask
endmodule // hsr_host_model

/* verification/test_hsr_sched_regs.sv */
// self-checking bench for the scheduler and memory pointer registers
// assumes: 40 mhz clock, one millisecond is 40000 cycles
`timescale 1ns/1ps
module test_hsr_sched_regs;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0]  wstrb;
  wire [1:0]  bresp, rresp, pio_bank;
  wire [2:0]  walk;
  wire [15:0] pio_addr;
  wire        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  wire        rvalid, rready, done_int, pio_is_read, hub_cfg;
  reg         ref_clk = 0, rst = 1, hdr_valid = 0, hdr_skip = 0, async_done = 0;
  reg         periodic_done = 0, int_en = 0, int_ack = 0, pio_read = 0, pio_write = 0;
  integer     fails = 0, tests_run = 0, i, k, n;
  reg [31:0]  seed = 32'hf668d884, v, got;
  reg [1:0]   r;
  hsr_host_model u_host (.i_ref_clk(ref_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));
  hsr_sched_regs u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_hdr_valid(hdr_valid), .i_hdr_skip(hdr_skip), .i_async_done(async_done),
    .i_periodic_done(periodic_done), .i_done_int_en(int_en), .i_done_int_ack(int_ack),
    .o_walk_area(walk), .o_done_int(done_int), .i_pio_read(pio_read),
    .i_pio_write(pio_write), .o_pio_bank(pio_bank), .o_pio_addr(pio_addr),
    .o_pio_is_read(pio_is_read), .o_hub_force_cfg(hub_cfg));
  initial forever #12.5 ref_clk = ~ref_clk;
  // xorshift source, fixed start so runs repeat
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // pointer word after k reads; the address wraps at 16 bits
  function [31:0] exp_ptr(input [1:0] b, input [15:0] a, input integer k);
    exp_ptr = {14'h0, b, a + k[15:0]};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) fails = fails + 1;
      if (g !== e) $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      u_host.rd(a, got, r);
      chk("rdata", e, got);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // watchdog: the whole run takes about 81k cycles, the timer tests most of it
  initial
  begin
    #(95000 * 25);
    fails = fails + 1;
    results;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(12'h014, 32'h0);
    rdc(12'h334, 32'h0);
    rdc(12'h338, 32'h0);
    rdc(12'h33c, 32'h0);
    u_host.rd(12'h100, got, r);
    chk("rresp", 32'h2, {30'h0, r});
    u_host.wr(12'h100, 32'h0, r);
    chk("bresp", 32'h2, {30'h0, r});
    $display("test reset done");
    hdr_valid <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      u_host.wr(12'h334, i, r);
      repeat (2) @(posedge ref_clk);
      chk("walk", i, {29'h0, walk});
    end
    hdr_skip <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("walk", 32'h0, {29'h0, walk});
    $display("test fill flags done");
    seed = xs(seed);
    u_host.wr(12'h338, seed, r);
    rdc(12'h338, seed);
    u_host.wr(12'h338, 32'h1, r);
    int_en <= 1'b1;
    @(posedge ref_clk) periodic_done <= 1'b1;
    @(posedge ref_clk) periodic_done <= 1'b0;
    repeat (41000) @(posedge ref_clk);
    chk("done_int", 32'h0, {31'h0, done_int});
    @(posedge ref_clk) async_done <= 1'b1;
    @(posedge ref_clk) async_done <= 1'b0;
    for (n = 0; done_int !== 1'b1 && n < 41000; n = n + 1) @(posedge ref_clk);
    chk("delay", 32'h1, {31'h0, n >= 39996 && n <= 40004});
    @(posedge ref_clk) int_ack <= 1'b1;
    @(posedge ref_clk) int_ack <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("done_int", 32'h0, {31'h0, done_int});
    $display("test timeout done");
    @(posedge ref_clk) pio_write <= 1'b1;
    @(posedge ref_clk) pio_write <= 1'b0;
    for (i = 0; i < 5; i = i + 1)
    begin
      seed = xs(seed);
      v = (i == 4) ? 32'hffff : seed;
      k = (i == 4) ? 1 : 1 + seed[31:30];
      u_host.wr(12'h33c, exp_ptr(i[1:0], v[15:0], 0), r);
      rdc(12'h33c, exp_ptr(i[1:0], v[15:0], 0));
      repeat (k)
      begin
        @(posedge ref_clk) pio_read <= 1'b1;
        @(posedge ref_clk) pio_read <= 1'b0;
      end
      #1;
      chk("bank", {30'h0, i[1:0]}, {30'h0, pio_bank});
      chk("pio_addr", exp_ptr(2'h0, v[15:0], k - 1), {16'h0, pio_addr});
      chk("pio_rd", 32'h1, {31'h0, pio_is_read});
      rdc(12'h33c, exp_ptr(i[1:0], v[15:0], k));
    end
    $display("test pointer done");
    chk("hub", 32'h0, {31'h0, hub_cfg});
    u_host.wr(12'h014, 32'h0, r);
    chk("hub", 32'h0, {31'h0, hub_cfg});
    u_host.wr(12'h014, 32'h1, r);
    chk("bresp", 32'h0, {30'h0, r});
    @(posedge ref_clk);
    chk("hub", 32'h1, {31'h0, hub_cfg});
    rdc(12'h014, 32'h0);
    u_host.wr(12'h014, 32'h0, r);
    chk("hub", 32'h1, {31'h0, hub_cfg});
    $display("test hub force done");
    results;
  end
endmodule // test_hsr_sched_regs
